// *** src/esm_pkg.sv ***
// esm_pkg: constants and types shared by the embedded sram macro model
// assumes a single 50 MHz clock and same-clock host logic on the command pins
package esm_pkg;

    // ***************************************************************
    // array geometry
    // ***************************************************************
    localparam int unsigned WORDS      = 16384;
    localparam int unsigned DATA_W     = 64;
    localparam int unsigned BYTES      = DATA_W / 8;
    localparam int unsigned ADR_W      = 15;
    localparam int unsigned IDX_W      = $clog2(WORDS);

    // ***************************************************************
    // reset values and timing counts
    // ***************************************************************
    localparam logic [DATA_W-1:0] DOUT_RST = 64'h0000_0000_0000_0000;
    localparam int unsigned RESET_MIN_CYC  = 10;
    localparam int unsigned BOOT_CYC       = 128;
    localparam int unsigned BOOT_W         = $clog2(BOOT_CYC + 1);
    localparam logic [BOOT_W-1:0] BOOT_LAST = BOOT_W'(BOOT_CYC - 1);
    localparam logic [BOOT_W-1:0] BOOT_RST  = '0;

    // ***************************************************************
    // states
    // ***************************************************************
    typedef enum logic [1:0]
    {
        ESM_ST_BOOT  = 2'h0,
        ESM_ST_READY = 2'h1
    } esm_state_t;

endpackage

// *** src/esm_mem_if.sv ***
// esm_mem_if: port bundle between the command front end and the storage array
// assumes both ends run on the same clock; rdata comes from a register
`timescale 1ns/10ps
interface esm_mem_if;

    logic                                  re;
    logic                                  we;
    logic [esm_pkg::BYTES-1:0]             ben;
    logic [esm_pkg::IDX_W-1:0]             addr;
    logic [esm_pkg::DATA_W-1:0]            wdata;
    logic [esm_pkg::DATA_W-1:0]            rdata;

    modport ctrl
    (
        output re,
        output we,
        output ben,
        output addr,
        output wdata,
        input  rdata
    );

    modport mem
    (
        input  re,
        input  we,
        input  ben,
        input  addr,
        input  wdata,
        output rdata
    );

endinterface

// *** src/esm_array.sv ***
// esm_array: 16384 x 64 storage with per-byte write and registered read
// assumes re and we are never high together; the front end guarantees it
`timescale 1ns/10ps
module esm_array
(
    input wire logic   clk_sys,
    esm_mem_if.mem     mif
);

    // ***************************************************************
    // storage
    // ***************************************************************
    // no reset on the array: contents survive reset, unwritten words read unknown
    logic [esm_pkg::DATA_W-1:0] mem [esm_pkg::WORDS];
    logic [esm_pkg::DATA_W-1:0] rd_q;

    always_ff @(posedge clk_sys)
    begin
        if (mif.we)
        begin
            for (int b = 0; b < esm_pkg::BYTES; b++)
            begin
                if (mif.ben[b])
                begin
                    mem[mif.addr][8*b +: 8] <= mif.wdata[8*b +: 8];
                end
            end
        end
        if (mif.re)
        begin
            rd_q <= mem[mif.addr];
        end
    end

    assign mif.rdata = rd_q;

endmodule

// *** src/esm_top.sv ***
// esm_top: pipelined embedded sram macro, command decode, read pipeline, boot timer
// assumes host logic on clk_sys drives the strobes; no synchronisers needed
`timescale 1ns/10ps
// Summary of operation
// RL1 - host never drives both strobes low
// RL2 - read strobe low alone reads word
// RL3 - write strobe low alone writes word
// RL4 - both strobes high: no operation
// RL5 - address and strobes captured on rising edge
// RL6 - read data one cycle after next edge
// RL7 - write data captured with write strobe
// RL8 - byte enable low stores that byte
// RL9 - byte enable high keeps stored byte
// RL10 - enable bit n governs byte n
// RL11 - 16384 words of 64 bits
// RL12 - synchronous reset puts state machines known
// RL13 - reset never clears stored words
// RL14 - clock runs two cycles before reset
// RL15 - host holds reset at least ten cycles
// RL16 - host waits 128 cycles before access
// RL17 - one command accepted every clock edge
// RL18 - unwritten words read as unknown
// RL19 - illegal command flagged, memory untouched
module esm_top
(
    input  wire logic                              clk_sys,
    input  wire logic                              reset,
    input  wire logic [esm_pkg::ADR_W-1:0]         adr,
    input  wire logic [esm_pkg::BYTES-1:0]         bwe_n,
    input  wire logic                              rd_n,
    input  wire logic                              wr_n,
    input  wire logic [esm_pkg::DATA_W-1:0]        din,
    output logic      [esm_pkg::DATA_W-1:0]        dout,
    output logic                                   rd_valid,
    output logic                                   err_illegal,
    output logic                                   init_done
);

    // ***************************************************************
    // command decode
    // ***************************************************************
    logic cmd_read;
    logic cmd_write;
    logic cmd_nop;
    logic cmd_bad;

    // commands are ignored while reset is high so a reset never touches the array
    always_comb
    begin
        cmd_read  = !reset && !rd_n &&  wr_n;    // RL2
        cmd_write = !reset &&  rd_n && !wr_n;    // RL3 RL13
        cmd_nop   = !reset &&  rd_n &&  wr_n;    // RL4
        cmd_bad   = !reset && !rd_n && !wr_n;    // RL19
    end

    esm_mem_if mif ();

    // array samples these on the same edge as the strobes
    always_comb
    begin
        mif.re    = cmd_read;                     // RL5
        mif.we    = cmd_write;                    // RL7
        mif.ben   = ~bwe_n;                       // RL8 RL9 RL10
        mif.addr  = adr[esm_pkg::IDX_W-1:0];      // RL11
        mif.wdata = din;                          // RL7
    end

    esm_array u_array
    (
        .clk_sys (clk_sys),
        .mif     (mif.mem)
    );

    // ***************************************************************
    // read pipeline
    // ***************************************************************
    logic                          rd_pend;
    logic                          next_rd_pend;
    logic [esm_pkg::DATA_W-1:0]    next_dout;
    logic                          next_rd_valid;
    logic                          next_err_illegal;

    always_comb
    begin
        next_rd_pend     = cmd_read;              // RL17
        next_rd_valid    = rd_pend;               // RL6
        next_dout        = dout;
        if (rd_pend)
        begin
            next_dout = mif.rdata;                // RL6 RL18
        end
        next_err_illegal = cmd_bad;               // RL19
        if (reset)
        begin
            next_rd_pend     = 1'b0;              // RL12
            next_rd_valid    = 1'b0;
            next_dout        = esm_pkg::DOUT_RST;
            next_err_illegal = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        rd_pend     <= next_rd_pend;
        rd_valid    <= next_rd_valid;
        dout        <= next_dout;
        err_illegal <= next_err_illegal;
    end

    // ***************************************************************
    // boot timer
    // ***************************************************************
    // status only: commands are not blocked, the host owns the wait
    esm_pkg::esm_state_t           state;
    esm_pkg::esm_state_t           next_state;
    logic [esm_pkg::BOOT_W-1:0]    boot_cnt;
    logic [esm_pkg::BOOT_W-1:0]    next_boot_cnt;
    logic                          next_init_done;

    always_comb
    begin
        next_state     = state;
        next_boot_cnt  = boot_cnt;
        next_init_done = init_done;
        case (state)
            esm_pkg::ESM_ST_BOOT:
            begin
                if (boot_cnt == esm_pkg::BOOT_LAST)
                begin
                    next_state     = esm_pkg::ESM_ST_READY;   // RL16
                    next_init_done = 1'b1;
                end
                else
                begin
                    next_boot_cnt = boot_cnt + 1'b1;
                end
            end
            esm_pkg::ESM_ST_READY:
            begin
                next_init_done = 1'b1;
            end
            default:
            begin
                next_state = esm_pkg::ESM_ST_BOOT;
            end
        endcase
        if (reset)
        begin
            next_state     = esm_pkg::ESM_ST_BOOT;             // RL12
            next_boot_cnt  = esm_pkg::BOOT_RST;
            next_init_done = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        state     <= next_state;
        boot_cnt  <= next_boot_cnt;
        init_done <= next_init_done;
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    sequence s_read;
        !reset && !rd_n && wr_n;
    endsequence

    sequence s_write;
        !reset && rd_n && !wr_n;
    endsequence

    AST_READ_LATENCY: assert property (@(posedge clk_sys) disable iff (reset) // RL6
        s_read |-> ##2 rd_valid)
        else $error("read data not valid two edges after command");

    AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (reset) // RL2
        s_read ##1 1'b1 |=> dout == $past(mif.rdata))
        else $error("read data does not match array output");

    AST_WRITE_SAME_EDGE: assert property (@(posedge clk_sys) disable iff (reset) // RL7
        s_write |-> mif.we && !mif.re && mif.wdata == din)
        else $error("write data not presented with write strobe");

    AST_BYTE_MAP: assert property (@(posedge clk_sys) disable iff (reset) // RL10
        s_write |-> mif.ben == ~bwe_n && mif.addr == adr[esm_pkg::IDX_W-1:0])
        else $error("byte enables or address mapped wrongly");

    AST_NOP_IDLE: assert property (@(posedge clk_sys) disable iff (reset) // RL4
        rd_n && wr_n |-> !mif.we && !mif.re ##2 !rd_valid)
        else $error("no-operation cycle touched the array");

    AST_ILLEGAL_FLAG: assert property (@(posedge clk_sys) disable iff (reset) // RL19
        !rd_n && !wr_n |-> !mif.we && !mif.re ##1 err_illegal)
        else $error("illegal command not flagged or not blocked");

    AST_BACK_TO_BACK: assert property (@(posedge clk_sys) disable iff (reset) // RL17
        s_read ##1 s_read |=> rd_valid [*2])
        else $error("back to back reads lost a beat");

    AST_RESET_STATE: assert property (@(posedge clk_sys) // RL12
        reset |-> !mif.we && !mif.re
        ##1 (!rd_valid && !err_illegal && !init_done && dout == esm_pkg::DOUT_RST))
        else $error("reset left state unknown");

    AST_BOOT_DONE: assert property (@(posedge clk_sys) disable iff (reset) // RL16
        state == esm_pkg::ESM_ST_BOOT && boot_cnt == esm_pkg::BOOT_LAST
        |=> init_done && $stable(boot_cnt))
        else $error("boot timer did not finish on count");

    AST_DONE_STABLE: assert property (@(posedge clk_sys) disable iff (reset) // RL16
        init_done |=> init_done)
        else $error("init_done dropped without reset");

endmodule

// *** dv/esm_host.sv ***
// esm_host: host logic model driving the macro command pins
// assumes one clk_sys; the bench calls cmd and idle in program order
`timescale 1ns/10ps
module esm_host
(
    input  wire logic        clk_sys,
    output logic [14:0]      adr,
    output logic [7:0]       bwe_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic [63:0]      din
);
    // ***************************************************************
    // pin drive
    // ***************************************************************
    initial
    begin
        rd_n  = 1'b1;
        wr_n  = 1'b1;
        adr   = 15'h0000;
        bwe_n = 8'hff;
        din   = 64'h0;
    end

    // both strobes low only when the bench passes them so on purpose
    task automatic cmd(input logic rn, input logic wn, input logic [14:0] a,
                       input logic [7:0] m, input logic [63:0] d);
        @(posedge clk_sys);
        #1;
        rd_n  = rn;
        wr_n  = wn;
        adr   = a;
        bwe_n = m;
        din   = d;
    endtask

    // idle cycle: nop, stale values turned round so nothing leans on them
    task automatic idle();
        cmd(1'b1, 1'b1, ~adr, ~bwe_n, ~din);
    endtask
endmodule

// *** dv/testbench.sv ***
// testbench: scoreboard bench for esm_top with a host model
// assumes clk_sys at 50 MHz and the reset polarity of esm_top
`timescale 1ns/10ps
module testbench;
    typedef struct {logic [63:0] data; bit ill; int due;} esm_note_t;
    logic        clk_sys;
    logic        reset;
    logic [14:0] adr;
    logic [7:0]  bwe_n;
    logic        rd_n;
    logic        wr_n;
    logic [63:0] din;
    logic [63:0] dout;
    logic        rd_valid;
    logic        err_illegal;
    logic        init_done;
    esm_note_t   notes[$];
    logic [63:0] shadow[int];
    int          cyc = 0;
    int          num_errors = 0;
    int          checks = 0;
    int          k;
    logic [63:0] d;
    logic [14:0] a;

    esm_host host (.clk_sys(clk_sys), .adr(adr), .bwe_n(bwe_n), .rd_n(rd_n),
                   .wr_n(wr_n), .din(din));
    esm_top DUT (.clk_sys(clk_sys), .reset(reset), .adr(adr), .bwe_n(bwe_n),
                 .rd_n(rd_n), .wr_n(wr_n), .din(din), .dout(dout),
                 .rd_valid(rd_valid), .err_illegal(err_illegal), .init_done(init_done));

    // ***************************************************************
    // clock and helpers
    // ***************************************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) cyc <= cyc + 1;

    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // reads and illegal commands leave a note; writes update the shadow
    task automatic acc(logic rn, logic wn, logic [14:0] a, logic [7:0] m, logic [63:0] dv);
        int          i;
        logic [63:0] w;
        host.cmd(rn, wn, a, m, dv);
        i = int'(a[13:0]);
        w = shadow.exists(i) ? shadow[i] : 'x;
        if (!rn && wn) notes.push_back('{w, 1'b0, cyc + 2});
        if (!rn && !wn) notes.push_back('{'x, 1'b1, cyc + 1});
        if (rn && !wn)
        begin
            for (int n = 0; n < 8; n++)
                if (!m[n]) w[8*n+:8] = dv[8*n+:8];
            shadow[i] = w;
        end
    endtask

    // ***************************************************************
    // answer monitor
    // ***************************************************************
    always @(negedge clk_sys)
    begin : mon
        esm_note_t n;
        // a read and a later illegal command can answer together; the read is older
        if (rd_valid === 1'b1)
        begin
            n = notes.size() ? notes.pop_front() : '{'x, 1'b1, -1};
            chk("read cycle", 64'(n.due), 64'(cyc));
            chk("read kind", 64'h0, 64'(n.ill));
            chk("read data", n.data, dout);
        end
        if (err_illegal === 1'b1)
        begin
            n = notes.size() ? notes.pop_front() : '{'x, 1'b0, -1};
            chk("illegal cycle", 64'(n.due), 64'(cyc));
            chk("illegal kind", 64'h1, 64'(n.ill));
        end
    end

    task automatic give_verdict();
        $display("counts: %0d checks, %0d mismatches", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial
    begin
        reset = 1'b1;
        void'($urandom(95571));
        repeat (esm_pkg::RESET_MIN_CYC) @(posedge clk_sys);
        #1 reset = 1'b0;
        for (k = 1; k < 200 && init_done !== 1'b1; k++)
        begin
            @(posedge clk_sys);
            #1;
        end
        chk("boot length", 64'(esm_pkg::BOOT_CYC + 1), 64'(k));
        $display("test boot done");

        // back to back random traffic near both ends of the array
        repeat (400)
        begin
            a = 15'($urandom);
            a[13:4] = ($urandom_range(0, 3) == 0) ? 10'h3ff : 10'h000;
            k = $urandom_range(0, 9);
            // k of 9 drives both strobes low on purpose
            acc(k > 3 && k != 9, k < 4 || k == 8, a, 8'($urandom), {$urandom, $urandom});
        end
        $display("test random traffic done");

        for (int n = 0; n < 8; n++)
        begin
            acc(1'b1, 1'b0, 15'h0064, ~(8'h01 << n), {$urandom, $urandom});
            acc(1'b0, 1'b1, 15'h4064, 8'hff, 64'h0);
        end
        $display("test byte lanes done");

        // reset in mid-run keeps words and ignores commands
        d = {$urandom, $urandom};
        acc(1'b1, 1'b0, 15'h00c8, 8'h00, d);
        repeat (4) host.idle();
        reset = 1'b1;
        host.cmd(1'b1, 1'b0, 15'h00c8, 8'h00, ~d);
        repeat (10) host.idle();
        reset = 1'b0;
        acc(1'b0, 1'b1, 15'h00c8, 8'hff, 64'h0);
        for (k = 0; k < 20 && notes.size() != 0; k++) host.idle();
        chk("pending notes", 64'h0, 64'(notes.size()));
        $display("test reset keeps contents done");
        give_verdict();
    end
endmodule
